// *** verilog/wdc_top.sv ***
// Purpose: Two-stage watchdog with one 8-bit I/O control/status register
// Assumes: por_n_i is power-up reset, rst_n_i is board hard reset
// Notes:   Stage one drives NMI, stage two drives board reset
// Function
// - Bit 7 reads 1 after a watchdog reset timeout until cleared.
// - Writing 0 clears a monitor bit; writing 1 leaves it.
// - Bit 7 zero at power-up; survives a watchdog-caused hard reset.
// - Bit 6 reads 1 after a timeout that drove NMI.
// - Bit 6 and bit 5 zero at power-up and after any hard reset.
// - Bit 5 low: timeout gives no reset and no bit 7.
// - Bit 5 high: timeout gives reset and sets bit 7 until cleared.
// - Reset follows the stage-one point by about 250 ms.
// - Timeout clears bit 5 by itself; no re-arm until rewritten.
// - Bit 4 low: timeout gives no NMI and no bit 6; reads back.
// - Bit 4 high: NMI after selected period, bit 6 set until cleared.
// - Bits 2:0 select minimum timeout from 250 ms up to 256 s.
// - Bits 2:0 zero after power-up and hard reset; read back.
`timescale 1ns/1ps
module wdc_top #(
    parameter int unsigned TICK_CYCLES = wdc_pkg::WDC_TICK_CYCLES
) (
    // Clock and resets
    input  wire logic                 clk_sys_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 por_n_i,
    // I/O port
    input  wire wdc_pkg::wdc_io_req_t io_req_i,
    output wdc_pkg::wdc_io_rsp_t      io_rsp_o,
    // Watchdog outputs
    output logic                      nmi_o,
    output logic                      board_reset_o
);
    localparam logic [wdc_pkg::WDC_DLY_W-1:0] DLY_LAST =
        wdc_pkg::WDC_DLY_W'(wdc_pkg::WDC_STG2_DELAY_MS - 1);
    localparam logic [wdc_pkg::WDC_HOLD_W-1:0] HOLD_LAST =
        wdc_pkg::WDC_HOLD_W'(wdc_pkg::WDC_RST_HOLD_CYC - 1);

    wdc_pkg::wdc_state_t st_reg;
    wdc_pkg::wdc_state_t st_next;
    wdc_pkg::wdc_por_t   po_reg;
    wdc_pkg::wdc_por_t   po_next;

    logic wr_hit;
    logic rd_hit;
    logic run;
    logic tick;
    logic restart;
    logic term_hit;
    logic timeout;
    logic enter_rst;
    logic hr_level;
    logic hr_active;
    logic [7:0] image;

    // Register image as read
    always_comb begin
        image = wdc_pkg::WDC_RESET_VAL;
        image[wdc_pkg::WDC_MON2_BIT] = po_reg.mon2;
        image[wdc_pkg::WDC_MON1_BIT] = st_reg.mon1;
        image[wdc_pkg::WDC_STG2_BIT] = st_reg.stg2_en;
        image[wdc_pkg::WDC_STG1_BIT] = st_reg.stg1_en;
        image[wdc_pkg::WDC_TSEL_LSB +: wdc_pkg::WDC_TSEL_W] = st_reg.tsel;
    end

    assign wr_hit   = io_req_i.wr && (io_req_i.addr == wdc_pkg::WDC_IO_ADDR);
    assign rd_hit   = io_req_i.rd && (io_req_i.addr == wdc_pkg::WDC_IO_ADDR);
    assign run      = st_reg.stg1_en || st_reg.stg2_en;
    // Prescaler keeps ticking through the stage-two delay even with both enables clear
    assign restart  = (st_reg.fsm == wdc_pkg::WDC_IDLE) && (wr_hit || !run);
    assign term_hit = (st_reg.count == wdc_pkg::wdc_term_ms(st_reg.tsel) - 1'b1);
    assign timeout  = run && tick && term_hit && !wr_hit;
    assign enter_rst = (st_reg.fsm == wdc_pkg::WDC_PEND) && tick && (st_reg.dly == DLY_LAST);
    assign hr_active = !hr_level;

    wdc_tick #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_tick (
        .clk_sys_i(clk_sys_i),
        .rst_n_i  (rst_n_i),
        .restart_i(restart),
        .tick_o   (tick)
    );

    wdc_sync u_hr_sync (
        .clk_sys_i(clk_sys_i),
        .rst_n_i  (por_n_i),
        .async_i  (rst_n_i),
        .level_o  (hr_level)
    );

    // Board reset domain next state
    always_comb begin
        st_next = st_reg;
        st_next.rsp.rack  = rd_hit;
        st_next.rsp.rdata = rd_hit ? image : 8'h00;
        if (wr_hit) begin
            st_next.stg2_en = io_req_i.wdata[wdc_pkg::WDC_STG2_BIT];
            st_next.stg1_en = io_req_i.wdata[wdc_pkg::WDC_STG1_BIT];
            st_next.tsel = io_req_i.wdata[wdc_pkg::WDC_TSEL_LSB +: wdc_pkg::WDC_TSEL_W];
            if (!io_req_i.wdata[wdc_pkg::WDC_MON1_BIT]) begin
                st_next.mon1 = 1'b0;
            end
            if (run && st_reg.fsm == wdc_pkg::WDC_IDLE) begin
                st_next.count = '0;
            end
        end else if (!run) begin
            st_next.count = '0;
        end else if (tick) begin
            st_next.count = term_hit ? '0 : st_reg.count + 1'b1;
        end
        if (timeout) begin
            if (st_reg.stg1_en) begin
                st_next.mon1 = 1'b1;
            end
            st_next.stg2_en = 1'b0;
        end
        case (st_reg.fsm)
            wdc_pkg::WDC_IDLE: begin
                if (timeout && st_reg.stg2_en) begin
                    st_next.fsm = wdc_pkg::WDC_PEND;
                    st_next.dly = '0;
                end
            end
            wdc_pkg::WDC_PEND: begin
                if (enter_rst) begin
                    st_next.fsm  = wdc_pkg::WDC_RST;
                    st_next.hold = '0;
                end else if (tick) begin
                    st_next.dly = st_reg.dly + 1'b1;
                end
            end
            wdc_pkg::WDC_RST: begin
                if (st_reg.hold == HOLD_LAST) begin
                    st_next.fsm = wdc_pkg::WDC_IDLE;
                end else begin
                    st_next.hold = st_reg.hold + 1'b1;
                end
            end
            default: begin
                st_next.fsm = wdc_pkg::WDC_IDLE;
            end
        endcase
    end

    // Hard reset clears every bit here
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Power-up domain next state; set wins over clear
    always_comb begin
        po_next = po_reg;
        po_next.hr_prev = hr_active;
        if (hr_active && !po_reg.cause) begin
            po_next.mon2 = 1'b0;
        end
        if (po_reg.hr_prev && !hr_active) begin
            po_next.cause = 1'b0;
        end
        if (wr_hit && !io_req_i.wdata[wdc_pkg::WDC_MON2_BIT]) begin
            po_next.mon2 = 1'b0;
        end
        if (enter_rst) begin
            po_next.mon2  = 1'b1;
            po_next.cause = 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge por_n_i) begin
        if (!por_n_i) begin
            po_reg <= '0;
        end else begin
            po_reg <= po_next;
        end
    end

    // NMI held while its flag stands
    assign nmi_o         = st_reg.mon1;
    assign board_reset_o = (st_reg.fsm == wdc_pkg::WDC_RST);
    assign io_rsp_o      = st_reg.rsp;

    // Checks
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_arm;
        timeout && st_reg.stg2_en;
    endsequence

    sequence s_pend_hold;
        (st_reg.fsm == wdc_pkg::WDC_PEND) [*8];
    endsequence

    a_mon1_on_nmi: assert property (timeout && st_reg.stg1_en |=> st_reg.mon1 && nmi_o)
        else $error("stage one flag not set on timeout");

    a_nmi_disabled: assert property (timeout && !st_reg.stg1_en && !st_reg.mon1 ##1 !wr_hit |-> !nmi_o)
        else $error("NMI raised while stage one disabled");

    a_stg2_autoclr: assert property (timeout |=> !st_reg.stg2_en)
        else $error("stage two enable survived timeout");

    a_no_rst_disabled: assert property (timeout && !st_reg.stg2_en && st_reg.fsm == wdc_pkg::WDC_IDLE
        |=> st_reg.fsm == wdc_pkg::WDC_IDLE)
        else $error("reset armed while stage two disabled");

    a_pend_before_rst: assert property (s_arm |=> s_pend_hold)
        else $error("reset did not wait after timeout");

    a_rst_delay_end: assert property ($rose(board_reset_o) |-> $past(st_reg.dly) == DLY_LAST
        && $past(st_reg.fsm) == wdc_pkg::WDC_PEND && $past(tick))
        else $error("reset not at end of stage two delay");

    a_rst_sets_mon2: assert property ($rose(board_reset_o) |-> po_reg.mon2)
        else $error("stage two flag not set with reset");

    a_mon1_clear: assert property (wr_hit && !io_req_i.wdata[wdc_pkg::WDC_MON1_BIT] && !timeout
        |=> !st_reg.mon1 && !nmi_o)
        else $error("stage one flag not cleared by zero");

    a_mon1_keep: assert property (wr_hit && io_req_i.wdata[wdc_pkg::WDC_MON1_BIT] && st_reg.mon1
        |=> st_reg.mon1)
        else $error("stage one flag lost on write of one");

    a_restart: assert property (wr_hit && run && st_reg.fsm == wdc_pkg::WDC_IDLE |=> st_reg.count == '0)
        else $error("count not restarted by write");

    a_tsel_read: assert property (wr_hit |=> st_reg.tsel == $past(io_req_i.wdata[2:0]))
        else $error("timeout select not stored");

    a_read_image: assert property (rd_hit |=> io_rsp_o.rack && io_rsp_o.rdata[4] == $past(st_reg.stg1_en)
        && io_rsp_o.rdata[3] == 1'b0)
        else $error("read data wrong");

    a_mon2_hard_rst: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        hr_active && !po_reg.cause && !enter_rst |=> !po_reg.mon2)
        else $error("stage two flag survived foreign reset");

    a_cause_on_rst: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        enter_rst |=> po_reg.cause)
        else $error("reset cause not recorded");

    a_mon2_set_only: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        !po_reg.mon2 && !enter_rst |=> !po_reg.mon2)
        else $error("stage two flag set without reset");

    a_mon2_keep: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        wr_hit && io_req_i.wdata[wdc_pkg::WDC_MON2_BIT] && po_reg.mon2 && !hr_active |=> po_reg.mon2)
        else $error("stage two flag lost on write of one");

    a_mon2_clear: assert property (@(posedge clk_sys_i) disable iff (!por_n_i)
        wr_hit && !io_req_i.wdata[wdc_pkg::WDC_MON2_BIT] && !enter_rst |=> !po_reg.mon2)
        else $error("stage two flag not cleared by zero");

    a_mon1_set_only: assert property (!st_reg.mon1 && !(timeout && st_reg.stg1_en) |=> !st_reg.mon1)
        else $error("stage one flag set without timeout");

    a_mon1_no_stg1: assert property (timeout && !st_reg.stg1_en && !st_reg.mon1 |=> !st_reg.mon1)
        else $error("stage one flag set while disabled");

    a_nmi_source: assert property ($rose(nmi_o) |-> $past(timeout) && $past(st_reg.stg1_en))
        else $error("NMI raised without stage one timeout");

    a_stg1_store: assert property (wr_hit
        |=> st_reg.stg1_en == $past(io_req_i.wdata[wdc_pkg::WDC_STG1_BIT]))
        else $error("stage one enable not stored");

    a_stg2_store: assert property (wr_hit
        |=> st_reg.stg2_en == $past(io_req_i.wdata[wdc_pkg::WDC_STG2_BIT]))
        else $error("stage two enable not stored");

    a_stg2_arm: assert property (timeout && st_reg.stg2_en && st_reg.fsm == wdc_pkg::WDC_IDLE
        |=> st_reg.fsm == wdc_pkg::WDC_PEND && st_reg.dly == '0)
        else $error("stage two delay not started");

    a_dly_step: assert property (st_reg.fsm == wdc_pkg::WDC_PEND && tick && !enter_rst
        |=> st_reg.dly == $past(st_reg.dly) + 1'b1)
        else $error("stage two delay not counting");

    a_no_rst_unless_pend: assert property (!board_reset_o && !enter_rst |=> !board_reset_o)
        else $error("reset raised outside stage two delay");

    sequence s_rst_hold;
        board_reset_o [*8];
    endsequence

    a_rst_hold: assert property ($rose(board_reset_o) |-> s_rst_hold)
        else $error("board reset too short");

    a_rst_release: assert property (board_reset_o && st_reg.hold == HOLD_LAST |=> !board_reset_o)
        else $error("board reset held too long");

    a_count_idle: assert property (!run && !wr_hit |=> st_reg.count == '0)
        else $error("count runs with both stages off");

    a_count_step: assert property (run && tick && !wr_hit && !term_hit
        |=> st_reg.count == $past(st_reg.count) + 1'b1)
        else $error("count missed a tick");

    a_count_wrap: assert property (timeout |=> st_reg.count == '0)
        else $error("count not wrapped at terminal count");

    a_read_flags: assert property (rd_hit |=> io_rsp_o.rdata[wdc_pkg::WDC_MON2_BIT] == $past(po_reg.mon2)
        && io_rsp_o.rdata[wdc_pkg::WDC_MON1_BIT] == $past(st_reg.mon1))
        else $error("flag bits read wrong");

    a_read_ctrl: assert property (rd_hit |=> io_rsp_o.rdata[wdc_pkg::WDC_STG2_BIT] == $past(st_reg.stg2_en)
        && io_rsp_o.rdata[2:0] == $past(st_reg.tsel))
        else $error("control bits read wrong");

    a_rsp_idle: assert property (!rd_hit |=> !io_rsp_o.rack && io_rsp_o.rdata == 8'h00)
        else $error("read answer without request");
endmodule

// *** verilog/wdc_pkg.sv ***
// Purpose: Shared constants and types of the two-stage watchdog
// Assumes: 200 MHz system clock, 8-bit I/O port register
// Notes:   Timeouts are counted in 1 ms ticks
package wdc_pkg;
    // Register location and layout
    localparam logic [15:0] WDC_IO_ADDR   = 16'h0079;
    localparam int          WDC_MON2_BIT  = 7;
    localparam int          WDC_MON1_BIT  = 6;
    localparam int          WDC_STG2_BIT  = 5;
    localparam int          WDC_STG1_BIT  = 4;
    localparam int          WDC_TSEL_LSB  = 0;
    localparam int          WDC_TSEL_W    = 3;
    localparam logic [7:0]  WDC_RESET_VAL = 8'h00;

    // Timing
    localparam int WDC_CLK_PERIOD_PS  = 5000;
    localparam int WDC_TICK_PERIOD_NS = 1000000;
    localparam int WDC_TICK_CYCLES    = WDC_TICK_PERIOD_NS * 1000 / WDC_CLK_PERIOD_PS;
    localparam int WDC_STG2_DELAY_MS  = 250;
    localparam int WDC_RST_HOLD_CYC   = 16;
    localparam int WDC_CNT_W          = 18;
    localparam int WDC_DLY_W          = 8;
    localparam int WDC_HOLD_W         = 5;
    localparam int WDC_TICK_W         = 32;

    // Terminal counts in ms
    localparam logic [WDC_CNT_W-1:0] WDC_TERM_0 = 18'h000FA;
    localparam logic [WDC_CNT_W-1:0] WDC_TERM_1 = 18'h001F4;
    localparam logic [WDC_CNT_W-1:0] WDC_TERM_2 = 18'h003E8;
    localparam logic [WDC_CNT_W-1:0] WDC_TERM_3 = 18'h01F40;
    localparam logic [WDC_CNT_W-1:0] WDC_TERM_4 = 18'h07D00;
    localparam logic [WDC_CNT_W-1:0] WDC_TERM_5 = 18'h0FA00;
    localparam logic [WDC_CNT_W-1:0] WDC_TERM_6 = 18'h1F400;
    localparam logic [WDC_CNT_W-1:0] WDC_TERM_7 = 18'h3E800;

    typedef enum logic [1:0] {
        WDC_IDLE = 2'b00,
        WDC_PEND = 2'b01,
        WDC_RST  = 2'b11
    } wdc_fsm_t;

    typedef struct packed {
        logic [15:0] addr;
        logic        wr;
        logic        rd;
        logic [7:0]  wdata;
    } wdc_io_req_t;

    typedef struct packed {
        logic       rack;
        logic [7:0] rdata;
    } wdc_io_rsp_t;

    // Board reset domain state
    typedef struct packed {
        logic                  stg2_en;
        logic                  stg1_en;
        logic [WDC_TSEL_W-1:0] tsel;
        logic                  mon1;
        logic [WDC_CNT_W-1:0]  count;
        wdc_fsm_t              fsm;
        logic [WDC_DLY_W-1:0]  dly;
        logic [WDC_HOLD_W-1:0] hold;
        wdc_io_rsp_t           rsp;
    } wdc_state_t;

    // Power-up domain state
    typedef struct packed {
        logic mon2;
        logic cause;
        logic hr_prev;
    } wdc_por_t;

    function automatic logic [WDC_CNT_W-1:0] wdc_term_ms(input logic [WDC_TSEL_W-1:0] sel);
        case (sel)
            3'h0:    wdc_term_ms = WDC_TERM_0;
            3'h1:    wdc_term_ms = WDC_TERM_1;
            3'h2:    wdc_term_ms = WDC_TERM_2;
            3'h3:    wdc_term_ms = WDC_TERM_3;
            3'h4:    wdc_term_ms = WDC_TERM_4;
            3'h5:    wdc_term_ms = WDC_TERM_5;
            3'h6:    wdc_term_ms = WDC_TERM_6;
            default: wdc_term_ms = WDC_TERM_7;
        endcase
    endfunction
endpackage

// *** verilog/wdc_sync.sv ***
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Level input from outside the clock domain
// Notes:   Output follows once stages two and three agree
`timescale 1ns/1ps
module wdc_sync (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // Level in and out
    input  wire logic async_i,
    output logic      level_o
);
    logic [2:0] stage_reg;
    logic       level_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            stage_reg <= 3'h0;
            level_reg <= 1'b0;
        end else begin
            stage_reg <= {stage_reg[1:0], async_i};
            if (stage_reg[1] == stage_reg[2]) begin
                level_reg <= stage_reg[2];
            end
        end
    end

    assign level_o = level_reg;
endmodule

// *** verilog/wdc_tick.sv ***
// Purpose: Millisecond tick prescaler
// Assumes: TICK_CYCLES clocks per tick
// Notes:   Restart clears the phase so a period starts fresh
`timescale 1ns/1ps
module wdc_tick #(
    parameter int unsigned TICK_CYCLES = wdc_pkg::WDC_TICK_CYCLES
) (
    // Clock and reset
    input  wire logic clk_sys_i,
    input  wire logic rst_n_i,
    // Control
    input  wire logic restart_i,
    output logic      tick_o
);
    localparam logic [wdc_pkg::WDC_TICK_W-1:0] LAST = wdc_pkg::WDC_TICK_W'(TICK_CYCLES - 1);

    logic [wdc_pkg::WDC_TICK_W-1:0] cnt_reg;
    logic                           tick_reg;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else if (restart_i) begin
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
        end else begin
            tick_reg <= (cnt_reg == LAST);
            cnt_reg  <= (cnt_reg == LAST) ? '0 : cnt_reg + 1'b1;
        end
    end

    assign tick_o = tick_reg;
endmodule

// *** bench/wdc_board.sv ***
// Purpose: Board reset logic model on the far side of the watchdog
// Assumes: Watchdog reset request is an active-high level
// Notes:   A watchdog request or a bench request holds the board in reset
`timescale 1ns/1ps
module wdc_board #(
    parameter int HOLD = 8
) (
    // Clock
    input  wire logic clk_sys_i,
    // Reset sources
    input  wire logic board_reset_i,
    input  wire logic hard_req_i,
    // Board hard reset
    output logic      rst_n_o
);
    logic [7:0] cnt_reg = 8'h00;

    // Stretch the watchdog pulse so the device sees a full hard reset
    always_ff @(posedge clk_sys_i) begin
        if (board_reset_i === 1'b1) begin
            cnt_reg <= 8'(HOLD);
        end else if (cnt_reg != 8'h00) begin
            cnt_reg <= cnt_reg - 8'h01;
        end
    end

    assign rst_n_o = !(hard_req_i || cnt_reg != 8'h00);
endmodule

// *** bench/wdc_top_tb.sv ***
// Purpose: Self-checking bench of the two-stage watchdog
// Assumes: TICK_CYCLES of 4, so one tick is four clocks
// Notes:   Timeouts measured in cycles from the write that starts them
`timescale 1ns/1ps
module wdc_top_tb;
    localparam logic [15:0] REG_ADDR = wdc_pkg::WDC_IO_ADDR;

    logic                 clk_sys_i;
    logic                 rst_n;
    logic                 por_n;
    logic                 hard_req;
    wdc_pkg::wdc_io_req_t io_req;
    wdc_pkg::wdc_io_rsp_t io_rsp;
    logic                 nmi;
    logic                 board_reset;
    int                   err_count = 0;
    int                   checks = 0;
    int                   cyc = 0;
    bit                   oth;

    wdc_top #(.TICK_CYCLES(4)) dut (
        .clk_sys_i     (clk_sys_i),
        .rst_n_i       (rst_n),
        .por_n_i       (por_n),
        .io_req_i      (io_req),
        .io_rsp_o      (io_rsp),
        .nmi_o         (nmi),
        .board_reset_o (board_reset)
    );

    wdc_board board (
        .clk_sys_i     (clk_sys_i),
        .board_reset_i (board_reset),
        .hard_req_i    (hard_req),
        .rst_n_o       (rst_n)
    );

    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    task automatic end_of_test();
        if (err_count == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            end_of_test();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        io_req <= '{addr: a, wr: 1'b1, rd: 1'b0, wdata: d};
        @(posedge clk_sys_i);
        io_req.wr <= 1'b0;
    endtask

    // Unmapped addresses must give no acknowledge at all
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        logic       ack;
        logic [7:0] d;
        ack = 1'b0;
        d = 8'h00;
        @(posedge clk_sys_i);
        io_req <= '{addr: a, wr: 1'b0, rd: 1'b1, wdata: 8'h00};
        @(posedge clk_sys_i);
        io_req.rd <= 1'b0;
        for (int k = 0; k < 3; k++) begin
            #1;
            if (!ack && io_rsp.rack === 1'b1) begin
                ack = 1'b1;
                d = io_rsp.rdata;
            end
            @(posedge clk_sys_i);
        end
        chk({7'h00, ack}, {7'h00, a == REG_ADDR});
        if (a == REG_ADDR) begin
            chk(d, exp);
        end
    endtask

    // First rise of nmi (sel 0) or board reset (sel 1); lo < 0 means none
    task automatic watch(input int lo, input int hi, input bit sel, output bit other);
        int hit;
        hit = 0;
        other = 1'b0;
        for (int k = 1; k <= hi; k++) begin
            @(posedge clk_sys_i);
            #1;
            if ((sel ? board_reset : nmi) === 1'b1 && hit == 0) begin
                hit = k;
            end
            if ((sel ? nmi : board_reset) !== 1'b0) begin
                other = 1'b1;
            end
        end
        chk({7'h00, (lo < 0) ? hit == 0 : (hit > lo && hit <= hi)}, 8'h01);
    endtask

    task automatic hard_reset();
        @(posedge clk_sys_i);
        hard_req <= 1'b1;
        repeat (8) @(posedge clk_sys_i);
        hard_req <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
    endtask

    initial begin
        io_req = '0;
        por_n = 1'b0;
        hard_req = 1'b1;
        repeat (4) @(posedge clk_sys_i);
        por_n <= 1'b1;
        hard_req <= 1'b0;
        @(posedge clk_sys_i);
        rd(REG_ADDR, 8'h00);
        rd(16'h0078, 8'h00);
        for (int t = 0; t < 8; t++) begin
            wr(REG_ADDR, 8'h08 | 8'(t));
            rd(REG_ADDR, 8'(t));
        end
        // Both stages off: nothing may fire
        wr(REG_ADDR, 8'h00);
        watch(-1, 1100, 1'b0, oth);
        chk({7'h00, oth}, 8'h00);
        wr(16'h0078, 8'h10);
        rd(REG_ADDR, 8'h00);
        // Stage one alone, shortest period
        wr(REG_ADDR, 8'h10);
        watch(990, 1010, 1'b0, oth);
        rd(REG_ADDR, 8'h50);
        watch(-1, 1100, 1'b1, oth);
        wr(REG_ADDR, 8'h50);
        rd(REG_ADDR, 8'h50);
        wr(REG_ADDR, 8'h10);
        rd(REG_ADDR, 8'h10);
        chk({7'h00, nmi}, 8'h00);
        // Rewrite in mid-period restarts the count
        wr(REG_ADDR, 8'h11);
        repeat (1500) @(posedge clk_sys_i);
        wr(REG_ADDR, 8'h11);
        watch(1990, 2010, 1'b0, oth);
        wr(REG_ADDR, 8'h00);
        rd(REG_ADDR, 8'h00);
        // Both stages: NMI, then board reset a stage-two delay later
        wr(REG_ADDR, 8'h30);
        watch(990, 1010, 1'b0, oth);
        chk({7'h00, oth}, 8'h00);
        rd(REG_ADDR, 8'h50);
        watch(975, 1000, 1'b1, oth);
        repeat (20) @(posedge clk_sys_i);
        rd(REG_ADDR, 8'h80);
        wr(REG_ADDR, 8'h00);
        rd(REG_ADDR, 8'h00);
        // Stage two alone: reset without NMI
        wr(REG_ADDR, 8'h20);
        watch(1990, 2012, 1'b1, oth);
        chk({7'h00, oth}, 8'h00);
        repeat (20) @(posedge clk_sys_i);
        rd(REG_ADDR, 8'h80);
        wr(REG_ADDR, 8'h87);
        rd(REG_ADDR, 8'h87);
        hard_reset();
        rd(REG_ADDR, 8'h00);
        end_of_test();
    end
endmodule
